/* hdl/asp_defs.svh */
// Behaviour
// - Bit period is (divisor+1)*8 clocks, or 16 clocks when divisor is zero.
// - Divisor is sixteen bits, split over high and low byte registers.
// - A frame opens with one start bit, then one to eight data bits.
// - Optional parity bit follows data: even, odd or none.
// - Frame closes with one or two stop bits.
// - Receiver flags parity, overrun, framing and break separately.
// - Two wake-up schemes: idle line between blocks, or address bit.
// - Buffer-ready flag while transmit holding buffer has room.
// - Shifter-empty flag while no character is being shifted out.
// - Receive-ready flag once a character sits in the receive buffer.
// - Break-detected flag when the receive line shows a break.
// - Summary error flag set while any of the four errors stands.
// - Separate transmit and receive interrupt enables; break ignores receive enable.
// - Transmitter and receiver double-buffered, enabled separately, full duplex.
// - Non-return-to-zero line; each level held for a whole bit period.
// - Drive transmit pin, sample receive pin; pins released when unused.
// - Data in bits 7-0; bits 15-8 read zero, writes to them ignored.
// - Hardware measures incoming start bit to find the remote baud rate.
// - Optional 16-level transmit and receive queues with their control registers.
`ifndef ASP_DEFS_SVH
`define ASP_DEFS_SVH
// ----------------------------------------
// Register addresses
// ----------------------------------------
`define ASP_A_COMM 16'h7050
`define ASP_A_CTL1 16'h7051
`define ASP_A_BAUDH 16'h7052
`define ASP_A_BAUDL 16'h7053
`define ASP_A_CTL2 16'h7054
`define ASP_A_RXST 16'h7055
`define ASP_A_RXDBG 16'h7056
`define ASP_A_RXBUF 16'h7057
`define ASP_A_TXBUF 16'h7059
`define ASP_A_TXQ 16'h705A
`define ASP_A_RXQ 16'h705B
`define ASP_A_QCT 16'h705C
`define ASP_A_PRI 16'h705F
// ----------------------------------------
// Field positions
// ----------------------------------------
`define ASP_C_ADDRMODE 3
`define ASP_C_PAREN 5
`define ASP_C_PAREVEN 6
`define ASP_C_STOP2 7
`define ASP_1_RXEN 0
`define ASP_1_TXEN 1
`define ASP_1_SLEEP 2
`define ASP_1_TXWAKE 3
`define ASP_1_RUN 5
`define ASP_2_TXIE 0
`define ASP_2_RXIE 1
`define ASP_Q_EN 7
`define ASP_Q_RUN 6
`define ASP_T_ABDONE 7
`define ASP_T_ABEN 6
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define ASP_RST_COMM 8'h07
`define ASP_RST_BYTE 8'h00
`define ASP_RST_QCTL 8'h40
`define ASP_DIV_ZERO_CYC 20'h00010
`define ASP_DIV_MULT_SH 3
`define ASP_IDLE_BITS 4'hA
`define ASP_QDEPTH 5'h10
`endif

/* hdl/asp_pkg.sv */
package asp_pkg;
    typedef enum logic {ASP_IDLE, ASP_RUN} asp_phase_t;
    typedef logic [7:0] asp_byte_t;
endpackage : asp_pkg

/* hdl/asp_uart.sv */
`timescale 1ns/100ps
`default_nettype none
`include "asp_defs.svh"
module asp_uart
    import asp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic busSel,
    input wire logic busWr,
    input wire logic busRd,
    input wire logic [15:0] busAddr,
    input wire logic [15:0] busWdata,
    output logic [15:0] busRdata,
    // Serial pins
    input wire logic serialInPin,
    output logic serialOutPin,
    output logic serialOutEn_n,
    output logic serialInUsed,
    // Interrupt requests
    output logic txIrq,
    output logic rxIrq
);
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    asp_byte_t comm_q, comm_d, ctl1_q, ctl1_d, ctl2_q, ctl2_d;
    asp_byte_t divH_q, divH_d, divL_q, divL_d, pri_q, pri_d;
    asp_byte_t txqc_q, txqc_d, rxqc_q, rxqc_d, qct_q, qct_d;
    logic pe_q, pe_d, oe_q, oe_d, fe_q, fe_d, brk_q, brk_d, wake_q, wake_d;
    logic [15:0] rdata_q, rdata_d;
    logic wrEn, rdEn, running, fifoOn;
    logic [15:0] div;
    logic [19:0] period;
    logic [4:0] cap;
    logic [3:0] dataLen;
    assign wrEn = busSel && busWr;
    assign rdEn = busSel && busRd;
    assign running = ctl1_q[`ASP_1_RUN];
    assign fifoOn = txqc_q[`ASP_Q_EN];
    assign div = {divH_q, divL_q};
    assign dataLen = {1'b0, comm_q[2:0]} + 4'h1;
    // Capacity 1 gives the plain double buffer
    assign cap = fifoOn ? `ASP_QDEPTH : 5'h01;
    always_comb begin
        if (div == 16'h0000) begin
            period = `ASP_DIV_ZERO_CYC;
        end else begin
            period = ({4'h0, div} + 20'h00001) << `ASP_DIV_MULT_SH;
        end
    end
    // ----------------------------------------
    // Input synchroniser
    // ----------------------------------------
    logic s1_q, s2_q, s3_q, rxLvl_q, rxPrev_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
            rxLvl_q <= 1'b1;
            rxPrev_q <= 1'b1;
        end else begin
            s1_q <= serialInPin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            rxLvl_q <= (s2_q == s3_q) ? s3_q : rxLvl_q;
            rxPrev_q <= rxLvl_q;
        end
    end
    // ----------------------------------------
    // Queues
    // ----------------------------------------
    asp_byte_t txMem [16];
    asp_byte_t rxMem [16];
    logic [3:0] txWp_q, txWp_d, txRp_q, txRp_d, rxWp_q, rxWp_d, rxRp_q, rxRp_d;
    logic [4:0] txN_q, txN_d, rxN_q, rxN_d;
    logic txPush, txPop, rxPush, rxPop, tx_buffer_ready_flag, rx_buffer_ready_flag;
    asp_byte_t rxByte;
    assign tx_buffer_ready_flag = txN_q < cap;
    assign rx_buffer_ready_flag = rxN_q != 5'h00;
    assign txPush = wrEn && busAddr == `ASP_A_TXBUF && tx_buffer_ready_flag;
    assign rxPop = rdEn && busAddr == `ASP_A_RXBUF && rx_buffer_ready_flag;
    always_comb begin
        txWp_d = txWp_q + {3'h0, txPush};
        txRp_d = txRp_q + {3'h0, txPop};
        txN_d = txN_q + {4'h0, txPush} - {4'h0, txPop};
        rxWp_d = rxWp_q + {3'h0, rxPush};
        rxRp_d = rxRp_q + {3'h0, rxPop};
        rxN_d = rxN_q + {4'h0, rxPush} - {4'h0, rxPop};
        if (!running || !txqc_q[`ASP_Q_RUN]) begin
            txWp_d = 4'h0;
            txRp_d = 4'h0;
            txN_d = 5'h00;
        end
        if (!running || !rxqc_q[`ASP_Q_RUN]) begin
            rxWp_d = 4'h0;
            rxRp_d = 4'h0;
            rxN_d = 5'h00;
        end
    end
    always_ff @(posedge clk) begin
        if (txPush) begin
            txMem[txWp_q] <= busWdata[7:0];
        end
        if (rxPush) begin
            rxMem[rxWp_q] <= rxByte;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txWp_q <= 4'h0;
            txRp_q <= 4'h0;
            txN_q <= 5'h00;
            rxWp_q <= 4'h0;
            rxRp_q <= 4'h0;
            rxN_q <= 5'h00;
        end else begin
            txWp_q <= txWp_d;
            txRp_q <= txRp_d;
            txN_q <= txN_d;
            rxWp_q <= rxWp_d;
            rxRp_q <= rxRp_d;
            rxN_q <= rxN_d;
        end
    end
    // ----------------------------------------
    // Transmitter
    // ----------------------------------------
    asp_phase_t txPh_q, txPh_d;
    logic [19:0] txCnt_q, txCnt_d;
    logic [12:0] txSh_q, txSh_d, frame;
    logic [3:0] txLeft_q, txLeft_d, fLen;
    logic txLoad, parBit;
    asp_byte_t txByte;
    assign txByte = txMem[txRp_q];
    assign txLoad = txPh_q == ASP_IDLE && running && ctl1_q[`ASP_1_TXEN] && txN_q != 5'h00;
    assign txPop = txLoad;
    always_comb begin
        frame = 13'h1FFF;
        frame[0] = 1'b0;
        parBit = ~comm_q[`ASP_C_PAREVEN];
        for (int i = 0; i < 8; i++) begin
            if (i < int'(dataLen)) begin
                frame[1 + i] = txByte[i];
                parBit = parBit ^ txByte[i];
            end
        end
        fLen = dataLen + 4'h1;
        if (comm_q[`ASP_C_ADDRMODE]) begin
            frame[fLen] = ctl1_q[`ASP_1_TXWAKE];
            parBit = parBit ^ ctl1_q[`ASP_1_TXWAKE];
            fLen = fLen + 4'h1;
        end
        if (comm_q[`ASP_C_PAREN]) begin
            frame[fLen] = parBit;
            fLen = fLen + 4'h1;
        end
        fLen = fLen + (comm_q[`ASP_C_STOP2] ? 4'h2 : 4'h1);
    end
    always_comb begin
        txPh_d = txPh_q;
        txCnt_d = txCnt_q;
        txSh_d = txSh_q;
        txLeft_d = txLeft_q;
        case (txPh_q)
            ASP_IDLE: begin
                if (txLoad) begin
                    txPh_d = ASP_RUN;
                    txSh_d = frame;
                    txLeft_d = fLen;
                    txCnt_d = period - 20'h00001;
                end
            end
            ASP_RUN: begin
                if (!running) begin
                    txPh_d = ASP_IDLE;
                end else if (txCnt_q != 20'h00000) begin
                    txCnt_d = txCnt_q - 20'h00001;
                end else begin
                    txSh_d = {1'b1, txSh_q[12:1]};
                    txLeft_d = txLeft_q - 4'h1;
                    txCnt_d = period - 20'h00001;
                    if (txLeft_q == 4'h1) begin
                        txPh_d = ASP_IDLE;
                    end
                end
            end
            default: txPh_d = ASP_IDLE;
        endcase
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txPh_q <= ASP_IDLE;
            txCnt_q <= 20'h00000;
            txSh_q <= 13'h1FFF;
            txLeft_q <= 4'h0;
        end else begin
            txPh_q <= txPh_d;
            txCnt_q <= txCnt_d;
            txSh_q <= txSh_d;
            txLeft_q <= txLeft_d;
        end
    end
    // ----------------------------------------
    // Receiver
    // ----------------------------------------
    asp_phase_t rxPh_q, rxPh_d;
    logic [19:0] rxCnt_q, rxCnt_d;
    logic [11:0] rxBits_q, rxBits_d;
    logic [3:0] rxIdx_q, rxIdx_d, idle_q, idle_d, need, p;
    logic rxIdleWake_q, rxIdleWake_d, rxDone, addrBit, parX, accept;
    logic rxOn;
    assign rxOn = running && ctl1_q[`ASP_1_RXEN];
    assign need = dataLen + 4'h2 + {3'h0, comm_q[`ASP_C_ADDRMODE]}
        + {3'h0, comm_q[`ASP_C_PAREN]};
    assign rxDone = rxPh_q == ASP_RUN && rxCnt_q == 20'h00000
        && rxIdx_q == need - 4'h1;
    always_comb begin
        rxByte = 8'h00;
        parX = ~comm_q[`ASP_C_PAREVEN];
        for (int i = 0; i < 8; i++) begin
            if (i < int'(dataLen)) begin
                rxByte[i] = rxBits_q[1 + i];
                parX = parX ^ rxBits_q[1 + i];
            end
        end
        p = dataLen + 4'h1;
        addrBit = 1'b0;
        if (comm_q[`ASP_C_ADDRMODE]) begin
            addrBit = rxBits_q[p];
            parX = parX ^ addrBit;
            p = p + 4'h1;
        end
        if (comm_q[`ASP_C_PAREN]) begin
            parX = parX ^ rxBits_q[p];
            p = p + 4'h1;
        end
    end
    // Sleeping receivers take only the wake character
    assign accept = !ctl1_q[`ASP_1_SLEEP]
        || (comm_q[`ASP_C_ADDRMODE] ? addrBit : rxIdleWake_q);
    assign rxPush = rxDone && accept && rxN_q < cap;
    always_comb begin
        rxPh_d = rxPh_q;
        rxCnt_d = rxCnt_q;
        rxBits_d = rxBits_q;
        rxIdx_d = rxIdx_q;
        idle_d = idle_q;
        rxIdleWake_d = rxIdleWake_q;
        case (rxPh_q)
            ASP_IDLE: begin
                rxCnt_d = (rxCnt_q == 20'h00000) ? period - 20'h00001 : rxCnt_q - 20'h00001;
                if (rxCnt_q == 20'h00000 && rxLvl_q && idle_q != `ASP_IDLE_BITS) begin
                    idle_d = idle_q + 4'h1;
                end
                if (rxOn && rxPrev_q && !rxLvl_q) begin
                    rxPh_d = ASP_RUN;
                    rxCnt_d = (period >> 1) - 20'h00001;
                    rxIdx_d = 4'h0;
                    rxBits_d = 12'h000;
                    rxIdleWake_d = idle_q == `ASP_IDLE_BITS;
                    idle_d = 4'h0;
                end
            end
            ASP_RUN: begin
                if (!rxOn) begin
                    rxPh_d = ASP_IDLE;
                end else if (rxCnt_q != 20'h00000) begin
                    rxCnt_d = rxCnt_q - 20'h00001;
                end else begin
                    rxBits_d[rxIdx_q] = rxLvl_q;
                    rxIdx_d = rxIdx_q + 4'h1;
                    rxCnt_d = period - 20'h00001;
                    // Glitch on start bit is dropped
                    if ((rxIdx_q == 4'h0 && rxLvl_q) || rxDone) begin
                        rxPh_d = ASP_IDLE;
                    end
                end
            end
            default: rxPh_d = ASP_IDLE;
        endcase
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxPh_q <= ASP_IDLE;
            rxCnt_q <= 20'h00000;
            rxBits_q <= 12'h000;
            rxIdx_q <= 4'h0;
            idle_q <= 4'h0;
            rxIdleWake_q <= 1'b0;
        end else begin
            rxPh_q <= rxPh_d;
            rxCnt_q <= rxCnt_d;
            rxBits_q <= rxBits_d;
            rxIdx_q <= rxIdx_d;
            idle_q <= idle_d;
            rxIdleWake_q <= rxIdleWake_d;
        end
    end
    // ----------------------------------------
    // Baud measurement
    // ----------------------------------------
    logic [19:0] ab_q, ab_d;
    logic abEnd;
    logic [16:0] abDiv;
    assign abEnd = qct_q[`ASP_T_ABEN] && !rxPrev_q && rxLvl_q && ab_q != 20'h00000;
    assign abDiv = ab_q[19:3] - 17'h00001;
    always_comb begin
        ab_d = ab_q;
        if (!qct_q[`ASP_T_ABEN] || rxLvl_q) begin
            ab_d = 20'h00000;
        end else if (ab_q != 20'hFFFFF) begin
            ab_d = ab_q + 20'h00001;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ab_q <= 20'h00000;
        end else begin
            ab_q <= ab_d;
        end
    end
    // ----------------------------------------
    // Register writes and flags
    // ----------------------------------------
    always_comb begin
        comm_d = comm_q;
        ctl1_d = ctl1_q;
        ctl2_d = ctl2_q;
        divH_d = divH_q;
        divL_d = divL_q;
        pri_d = pri_q;
        txqc_d = txqc_q;
        rxqc_d = rxqc_q;
        qct_d = qct_q;
        if (wrEn) begin
            case (busAddr)
                `ASP_A_COMM: comm_d = busWdata[7:0];
                `ASP_A_CTL1: ctl1_d = busWdata[7:0];
                `ASP_A_CTL2: ctl2_d = {6'h00, busWdata[1:0]};
                `ASP_A_BAUDH: divH_d = busWdata[7:0];
                `ASP_A_BAUDL: divL_d = busWdata[7:0];
                `ASP_A_TXQ: txqc_d = {busWdata[7:6], 6'h00};
                `ASP_A_RXQ: rxqc_d = {1'b0, busWdata[6], 6'h00};
                `ASP_A_QCT: qct_d = {qct_q[7] & ~busWdata[7], busWdata[6], 6'h00};
                `ASP_A_PRI: pri_d = busWdata[7:0];
                default: ;
            endcase
        end
        if (abEnd) begin
            {divH_d, divL_d} = (abDiv[16] || ab_q < 20'h00010) ? 16'h0000 : abDiv[15:0];
            qct_d[`ASP_T_ABDONE] = 1'b1;
            qct_d[`ASP_T_ABEN] = 1'b0;
        end
    end
    always_comb begin
        pe_d = pe_q;
        oe_d = oe_q;
        fe_d = fe_q;
        brk_d = brk_q;
        wake_d = wake_q;
        if (!running) begin
            {pe_d, oe_d, fe_d, brk_d, wake_d} = 5'h00;
        end
        // Set after clear so a new event wins
        if (rxDone) begin
            wake_d = comm_q[`ASP_C_ADDRMODE] ? addrBit : rxIdleWake_q;
            if (comm_q[`ASP_C_PAREN] && parX) begin
                pe_d = 1'b1;
            end
            // Stop level is this cycle's sample, not yet in rxBits_q
            if (!rxLvl_q) begin
                fe_d = 1'b1;
            end
            if (!rxLvl_q && (rxBits_q & ~(12'hFFF << (need - 4'h1))) == 12'h000) begin
                brk_d = 1'b1;
            end
            if (accept && rxN_q >= cap) begin
                oe_d = 1'b1;
            end
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            comm_q <= `ASP_RST_COMM;
            ctl1_q <= `ASP_RST_BYTE;
            ctl2_q <= `ASP_RST_BYTE;
            divH_q <= `ASP_RST_BYTE;
            divL_q <= `ASP_RST_BYTE;
            pri_q <= `ASP_RST_BYTE;
            txqc_q <= `ASP_RST_QCTL;
            rxqc_q <= `ASP_RST_QCTL;
            qct_q <= `ASP_RST_BYTE;
            {pe_q, oe_q, fe_q, brk_q, wake_q} <= 5'h00;
        end else begin
            comm_q <= comm_d;
            ctl1_q <= ctl1_d;
            ctl2_q <= ctl2_d;
            divH_q <= divH_d;
            divL_q <= divL_d;
            pri_q <= pri_d;
            txqc_q <= txqc_d;
            rxqc_q <= rxqc_d;
            qct_q <= qct_d;
            {pe_q, oe_q, fe_q, brk_q, wake_q} <= {pe_d, oe_d, fe_d, brk_d, wake_d};
        end
    end
    // ----------------------------------------
    // Read port and outputs
    // ----------------------------------------
    logic rxErr, txEmpty;
    assign rxErr = pe_q | oe_q | fe_q | brk_q;
    assign txEmpty = txPh_q == ASP_IDLE;
    always_comb begin
        rdata_d = 16'h0000;
        if (rdEn) begin
            case (busAddr)
                `ASP_A_COMM: rdata_d[7:0] = comm_q;
                `ASP_A_CTL1: rdata_d[7:0] = ctl1_q;
                `ASP_A_BAUDH: rdata_d[7:0] = divH_q;
                `ASP_A_BAUDL: rdata_d[7:0] = divL_q;
                `ASP_A_CTL2: rdata_d[7:0] = {tx_buffer_ready_flag, txEmpty, 4'h0, ctl2_q[1:0]};
                `ASP_A_RXST: rdata_d[7:0] = {rxErr, rx_buffer_ready_flag, brk_q, fe_q, oe_q, pe_q, wake_q, 1'b0};
                `ASP_A_RXDBG: rdata_d[7:0] = rxMem[rxRp_q];
                `ASP_A_RXBUF: rdata_d[7:0] = rxMem[rxRp_q];
                `ASP_A_TXQ: rdata_d[7:0] = {txqc_q[7:6], 1'b0, txN_q};
                `ASP_A_RXQ: rdata_d[7:0] = {rxqc_q[7:6], 1'b0, rxN_q};
                `ASP_A_QCT: rdata_d[7:0] = qct_q;
                `ASP_A_PRI: rdata_d[7:0] = pri_q;
                default: rdata_d = 16'h0000;
            endcase
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end
    assign busRdata = rdata_q;
    assign serialOutPin = (txPh_q == ASP_RUN) ? txSh_q[0] : 1'b1;
    assign serialOutEn_n = !(running && ctl1_q[`ASP_1_TXEN]);
    assign serialInUsed = rxOn;
    assign txIrq = ctl2_q[`ASP_2_TXIE] && tx_buffer_ready_flag;
    assign rxIrq = (ctl2_q[`ASP_2_RXIE] && (rx_buffer_ready_flag || rxErr)) || brk_q;
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_idle_high;
        @(posedge clk) disable iff (!rst_n) txPh_q == ASP_IDLE |-> serialOutPin;
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("line not high at idle");
    property p_start_low;
        @(posedge clk) disable iff (!rst_n) txLoad |=> !serialOutPin;
    endproperty
    a_start_low: assert property (p_start_low) else $error("no start bit");
    property p_div_zero;
        @(posedge clk) disable iff (!rst_n)
            txLoad && div == 16'h0000 && running |=> txCnt_q == 20'h0000F ##15 txCnt_q == 20'h00000;
    endproperty
    a_div_zero: assert property (p_div_zero) else $error("bit period not 16");
    property p_hold;
        @(posedge clk) disable iff (!rst_n)
            txPh_q == ASP_RUN && txCnt_q != 20'h00000 && running |=> $stable(serialOutPin);
    endproperty
    a_hold: assert property (p_hold) else $error("level changed mid bit");
    property p_upper_zero;
        @(posedge clk) disable iff (!rst_n) rdEn |=> busRdata[15:8] == 8'h00;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper byte not zero");
    property p_rx_ready;
        @(posedge clk) disable iff (!rst_n) rxPush && !rxPop |=> rx_buffer_ready_flag;
    endproperty
    a_rx_ready: assert property (p_rx_ready) else $error("ready not set");
    property p_break;
        @(posedge clk) disable iff (!rst_n)
            rxDone && rxBits_q == 12'h000 && !rxLvl_q && running |=> brk_q && rxErr;
    endproperty
    a_break: assert property (p_break) else $error("break missed");
    property p_tx_empty;
        @(posedge clk) disable iff (!rst_n) txLoad |=> !txEmpty;
    endproperty
    a_tx_empty: assert property (p_tx_empty) else $error("empty while shifting");
    property p_tx_full;
        @(posedge clk) disable iff (!rst_n) txN_q >= cap |-> !txPush;
    endproperty
    a_tx_full: assert property (p_tx_full) else $error("write taken while full");
endmodule : asp_uart
`default_nettype wire

/* test/asp_rem_node.sv */
`timescale 1ns/100ps
`default_nettype none
module asp_rem_node #(parameter int P = 16) (
    // Line pins
    input wire logic clk,
    input wire logic lineIn,
    output logic lineOut
);
    logic [7:0] gotByte;
    logic gotStop;
    initial lineOut = 1'b1;
    // ----------------
    // Frames
    // ----------------
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            lineOut <= f[i];
            repeat (P) @(posedge clk);
        end
    endtask : send
    task automatic brk();
        lineOut <= 1'b0;
        repeat (12 * P) @(posedge clk);
        lineOut <= 1'b1;
    endtask : brk
    // Mid-bit sampling tolerates a few cycles of skew
    task automatic listen();
        @(negedge lineIn);
        repeat (P / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (P) @(posedge clk);
            gotByte[i] = lineIn;
        end
        repeat (P) @(posedge clk);
        gotStop = lineIn;
    endtask : listen
endmodule : asp_rem_node
`default_nettype wire

/* test/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "asp_defs.svh"
`define CHK(a, e) begin samplesChecked++; if ((a) !== (e)) begin miscompares++; \
    $display("wrong value t=%0t got %h exp %h", $time, a, e); end end
module tb_top;
    import asp_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, busSel = 1'b0, busWr = 1'b0, busRd = 1'b0;
    logic [15:0] busAddr = 16'h0000, busWdata = 16'h0000, busRdata, rv;
    logic serialInPin, serialOutPin, serialOutEn_n, serialInUsed, txIrq, rxIrq;
    int miscompares = 0, samplesChecked = 0;
    always #2 clk = ~clk;
    asp_uart u_dut (.clk(clk), .rst_n(rst_n), .busSel(busSel), .busWr(busWr), .busRd(busRd),
        .busAddr(busAddr), .busWdata(busWdata), .busRdata(busRdata),
        .serialInPin(serialInPin), .serialOutPin(serialOutPin), .serialOutEn_n(serialOutEn_n),
        .serialInUsed(serialInUsed), .txIrq(txIrq), .rxIrq(rxIrq));
    asp_rem_node u_rem (.clk(clk), .lineIn(serialOutPin), .lineOut(serialInPin));
    // ----------------
    // Bus cycles
    // ----------------
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk) #1 {busSel, busWr, busAddr, busWdata} = {2'b11, a, d};
        @(posedge clk) #1 {busSel, busWr} = 2'b00;
    endtask : wr
    task automatic rd(input logic [15:0] a);
        @(posedge clk) #1 {busSel, busRd, busAddr} = {2'b11, a};
        @(posedge clk) #1 {busSel, busRd} = 2'b00;
        rv = busRdata;
    endtask : rd
    task automatic t_regs();
        rd(`ASP_A_COMM);
        `CHK(rv, 16'h0007)
        wr(`ASP_A_BAUDL, 16'hFF3C);
        rd(`ASP_A_BAUDL);
        `CHK(rv, 16'h003C)
        wr(`ASP_A_BAUDL, 16'h0000);
        rd(16'h7058);
        `CHK(rv, 16'h0000)
        $display("regs end");
    endtask : t_regs
    task automatic t_duplex();
        wr(`ASP_A_CTL1, 16'h0023);
        wr(`ASP_A_CTL2, 16'h0001);
        rd(`ASP_A_CTL2);
        `CHK(rv, 16'h00C1)
        `CHK({txIrq, serialOutEn_n, serialInUsed}, 3'b101)
        fork
            u_rem.listen();
            u_rem.send(8'h3C);
            wr(`ASP_A_TXBUF, 16'h00A5);
        join
        repeat (8) @(posedge clk);
        `CHK({u_rem.gotByte, u_rem.gotStop}, 9'h14B)
        rd(`ASP_A_RXST);
        `CHK(rv, 16'h0040)
        rd(`ASP_A_RXBUF);
        `CHK(rv, 16'h003C)
        rd(`ASP_A_RXST);
        `CHK(rv, 16'h0000)
        $display("duplex end");
    endtask : t_duplex
    // Queue fills while the transmitter is held off
    task automatic t_queue();
        wr(`ASP_A_COMM, 16'h0067);
        wr(`ASP_A_TXQ, 16'h00C0);
        wr(`ASP_A_CTL1, 16'h0021);
        `CHK(serialOutEn_n, 1'b1)
        repeat (3) wr(`ASP_A_TXBUF, 16'h0003);
        rd(`ASP_A_TXQ);
        `CHK(rv, 16'h00C3)
        fork
            u_rem.listen();
            wr(`ASP_A_CTL1, 16'h0023);
        join
        `CHK({u_rem.gotByte, u_rem.gotStop}, 9'h006)
        wr(`ASP_A_CTL1, 16'h0003);
        wr(`ASP_A_TXQ, 16'h0040);
        wr(`ASP_A_COMM, 16'h0007);
        wr(`ASP_A_CTL1, 16'h0023);
        $display("queue end");
    endtask : t_queue
    // Errors stay set until the run bit drops, so overrun is cleared before the parity case
    task automatic t_err();
        u_rem.send(8'h11);
        u_rem.send(8'h22);
        repeat (8) @(posedge clk);
        rd(`ASP_A_RXST);
        `CHK(rv & 16'h0088, 16'h0088)
        wr(`ASP_A_CTL1, 16'h0003);
        wr(`ASP_A_CTL1, 16'h0023);
        wr(`ASP_A_COMM, 16'h0027);
        u_rem.send(8'h01);
        // Receiver expects one bit more than the partner sends
        repeat (24) @(posedge clk);
        rd(`ASP_A_RXST);
        `CHK(rv & 16'h0084, 16'h0084)
        wr(`ASP_A_QCT, 16'h0040);
        u_rem.brk();
        repeat (8) @(posedge clk);
        rd(`ASP_A_RXST);
        `CHK(rv & 16'h00B0, 16'h00B0)
        `CHK(rxIrq, 1'b1)
        rd(`ASP_A_QCT);
        `CHK(rv, 16'h0080)
        rd(`ASP_A_BAUDL);
        `CHK(rv, 16'h0017)
        $display("errors end");
    endtask : t_err
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samplesChecked, miscompares);
        if (miscompares == 0 && samplesChecked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (10) @(posedge clk);
        #1 rst_n = 1'b1;
        t_regs();
        t_duplex();
        t_queue();
        t_err();
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
